/* File: core/fsr_dev.sv */
// The APB interface to the registers was chosen for this implementation.
module fsr_dev #(
  parameter int RST_CYCLES = fsr_pkg::RST_CYCLES,
  parameter logic [7:0] VENDOR_ID = 8'h5e // arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  fsr_link_if.dev link,
  input wire logic i_otp_we,
  input wire logic [fsr_pkg::SEC_AW-1:0] i_otp_addr,
  input wire logic [7:0] i_otp_data,
  input wire logic i_lock_flag,
  input wire logic i_vol_we,
  input wire logic [fsr_pkg::VOL_W-1:0] i_vol_data,
  output logic [fsr_pkg::VOL_W-1:0] o_vol_state,
  output logic o_reset_busy
);

  if (RST_CYCLES < 1 || RST_CYCLES >= 2 ** fsr_pkg::RST_CW) begin : g_bad_rst
    $error("RST_CYCLES out of range");
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] param_byte(input logic [23:0] a, input logic [7:0] vid);
    logic [31:0] w;
    w = fsr_pkg::PT_BLANK;
    if (a[23:5] == 19'h0) begin
      case ({a[7:2], 2'b00})
        fsr_pkg::PT_OFS_SIGNATURE: w = fsr_pkg::PT_SIGNATURE;
        fsr_pkg::PT_OFS_REV_COUNT: w = fsr_pkg::PT_REV_COUNT;
        fsr_pkg::PT_OFS_STD_HDR: w = fsr_pkg::PT_STD_HDR;
        fsr_pkg::PT_OFS_STD_PTR: w = fsr_pkg::PT_STD_PTR;
        fsr_pkg::PT_OFS_VND_HDR: w = {fsr_pkg::PT_VND_REV_LEN, vid};
        fsr_pkg::PT_OFS_VND_PTR: w = fsr_pkg::PT_VND_PTR;
        default: w = fsr_pkg::PT_BLANK;
      endcase
    end
    return w[{a[1:0], 3'b000} +: 8];
  endfunction : param_byte

  function automatic logic [4:0] phase_len(input fsr_pkg::fsr_dev_state_t s);
    case (s)
      fsr_pkg::DS_CMD: return fsr_pkg::LAST_OP_BIT;
      fsr_pkg::DS_ADDR: return fsr_pkg::LAST_ADDR_BIT;
      fsr_pkg::DS_DUMMY: return fsr_pkg::LAST_DUMMY_BIT;
      default: return 5'h1f;
    endcase
  endfunction : phase_len

  function automatic fsr_pkg::fsr_dev_state_t decode(input logic [7:0] op);
    case (op)
      fsr_pkg::OP_SEC_READ: return fsr_pkg::DS_ADDR;
      fsr_pkg::OP_PARAM_READ: return fsr_pkg::DS_ADDR;
      fsr_pkg::OP_RST_ENABLE: return fsr_pkg::DS_TAIL;
      fsr_pkg::OP_RST: return fsr_pkg::DS_TAIL;
      default: return fsr_pkg::DS_SKIP;
    endcase
  endfunction : decode

  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic is_param);
    if (is_param) begin
      return a + 24'h000001;
    end
    return {a[23:fsr_pkg::SEC_AW], a[fsr_pkg::SEC_AW-1:0] + fsr_pkg::SEC_ONE};
  endfunction : next_addr

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic cs_s1_q, cs_s2_q, cs_p_q;
  logic sclk_s1_q, sclk_s2_q, sclk_p_q;
  logic si_s1_q, si_s2_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_p_q <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_p_q <= 1'b0;
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_p_q <= cs_s2_q;
      sclk_s1_q <= link.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_p_q <= sclk_s2_q;
      si_s1_q <= link.si;
      si_s2_q <= si_s1_q;
    end
  end

  // ************************************************************
  // frame decode
  // ************************************************************
  fsr_pkg::fsr_dev_state_t st_q;
  logic [4:0] cnt_q;
  logic [23:0] in_q, addr_q;
  logic [7:0] op_q, osh_q;
  logic [2:0] ocnt_q;
  logic kind_q, tail_q, so_q, arm_q, busy_q;
  logic [fsr_pkg::RST_CW-1:0] rst_cnt_q;
  logic [fsr_pkg::VOL_W-1:0] vol_q;
  logic [7:0] sec_mem [fsr_pkg::SEC_BYTES];
  logic sclk_rise, sclk_fall, frame_end, phase_last, exact_op, rst_start;
  logic [23:0] in_next;
  logic [7:0] out_byte;

  always_comb begin
    sclk_rise = sclk_s2_q & ~sclk_p_q;
    sclk_fall = ~sclk_s2_q & sclk_p_q;
    frame_end = cs_s2_q & ~cs_p_q;
    in_next = {in_q[22:0], si_s2_q};
    phase_last = sclk_rise && (cnt_q == phase_len(st_q));
    exact_op = (st_q == fsr_pkg::DS_TAIL) && !tail_q && !sclk_rise;
    rst_start = frame_end && !busy_q && exact_op && arm_q
      && (op_q == fsr_pkg::OP_RST);
    out_byte = kind_q ? param_byte(addr_q, VENDOR_ID) : sec_mem[addr_q[fsr_pkg::SEC_AW-1:0]];
  end

  // a raised select ends every frame whatever its phase
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_q <= fsr_pkg::DS_IDLE;
      cnt_q <= 5'h00;
      in_q <= 24'h000000;
      op_q <= 8'h00;
      kind_q <= 1'b0;
      tail_q <= 1'b0;
    end else if (cs_s2_q) begin
      st_q <= fsr_pkg::DS_IDLE;
      cnt_q <= 5'h00;
      tail_q <= 1'b0;
    end else begin
      if (sclk_rise) begin
        in_q <= in_next;
        cnt_q <= phase_last ? 5'h00 : cnt_q + 5'h01;
      end
      case (st_q)
        fsr_pkg::DS_IDLE: st_q <= busy_q ? fsr_pkg::DS_SKIP : fsr_pkg::DS_CMD;
        fsr_pkg::DS_CMD: begin
          if (phase_last) begin
            op_q <= in_next[7:0];
            kind_q <= (in_next[7:0] == fsr_pkg::OP_PARAM_READ);
            st_q <= decode(in_next[7:0]);
          end
        end
        fsr_pkg::DS_ADDR: begin
          if (phase_last) begin
            st_q <= fsr_pkg::DS_DUMMY;
          end
        end
        fsr_pkg::DS_DUMMY: begin
          if (phase_last) begin
            st_q <= fsr_pkg::DS_DATA;
          end
        end
        fsr_pkg::DS_TAIL: begin
          if (sclk_rise) begin
            tail_q <= 1'b1;
          end
        end
        fsr_pkg::DS_DATA: st_q <= fsr_pkg::DS_DATA;
        fsr_pkg::DS_SKIP: st_q <= fsr_pkg::DS_SKIP;
        default: st_q <= fsr_pkg::DS_IDLE;
      endcase
    end
  end

  // ************************************************************
  // data output
  // ************************************************************
  // the next byte is fetched at the falling edge that shows its first bit,
  // so the address already points one past the byte being shifted
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      addr_q <= 24'h000000;
      so_q <= 1'b0;
      osh_q <= 8'h00;
      ocnt_q <= 3'h0;
    end else if (cs_s2_q) begin
      so_q <= 1'b0;
      ocnt_q <= 3'h0;
    end else if (st_q == fsr_pkg::DS_ADDR && phase_last) begin
      addr_q <= in_next;
    end else if (st_q == fsr_pkg::DS_DATA && sclk_fall) begin
      if (ocnt_q == 3'h0) begin
        so_q <= out_byte[7];
        osh_q <= {out_byte[6:0], 1'b0};
        ocnt_q <= fsr_pkg::LAST_BYTE_BIT;
        addr_q <= next_addr(addr_q, kind_q);
      end else begin
        so_q <= osh_q[7];
        osh_q <= {osh_q[6:0], 1'b0};
        ocnt_q <= ocnt_q - 3'h1;
      end
    end
  end

  assign link.so = so_q;

  // ************************************************************
  // security register store
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_otp_we && !i_lock_flag) begin
      sec_mem[i_otp_addr] <= i_otp_data;
    end
  end

  // ************************************************************
  // software reset
  // ************************************************************
  // any frame other than a clean enable, even a broken one, drops the arm
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      arm_q <= 1'b0;
      busy_q <= 1'b0;
      rst_cnt_q <= '0;
    end else if (frame_end && !busy_q) begin
      arm_q <= exact_op && (op_q == fsr_pkg::OP_RST_ENABLE);
      if (rst_start) begin
        busy_q <= 1'b1;
        rst_cnt_q <= fsr_pkg::RST_CW'(RST_CYCLES);
      end
    end else if (busy_q) begin
      arm_q <= 1'b0;
      rst_cnt_q <= rst_cnt_q - 1'b1;
      if (rst_cnt_q == fsr_pkg::RST_CW'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // a load in the very cycle of a reset wins so it is not lost
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      vol_q <= '0;
    end else if (i_vol_we) begin
      vol_q <= i_vol_data;
    end else if (rst_start) begin
      vol_q <= '0;
    end
  end

  assign o_vol_state = vol_q;
  assign o_reset_busy = busy_q;

endmodule : fsr_dev

/* File: core/fsr_pkg.sv */
package fsr_pkg;

  // ************************************************************
  // link command codes and frame layout
  // ************************************************************
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_PARAM_READ = 8'h5a;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [4:0] LAST_OP_BIT = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
  localparam logic [4:0] LAST_DUMMY_BIT = 5'h07;
  localparam logic [2:0] LAST_BYTE_BIT = 3'h7;
  localparam logic [6:0] OP_BITS = 7'h08;
  localparam logic [6:0] ADDR_BITS = 7'h18;
  localparam logic [6:0] DUMMY_BITS = 7'h08;
  localparam logic [2:0] MAX_RD_BYTES = 3'h4;

  // ************************************************************
  // security register store
  // ************************************************************
  localparam int SEC_AW = 10;
  localparam int SEC_BYTES = 1024;
  localparam logic [SEC_AW-1:0] SEC_ONE = 10'h001;

  // ************************************************************
  // parameter header words, byte 0 in bits 7:0
  // ************************************************************
  localparam logic [7:0] PT_OFS_SIGNATURE = 8'h00;
  localparam logic [7:0] PT_OFS_REV_COUNT = 8'h04;
  localparam logic [7:0] PT_OFS_STD_HDR = 8'h08;
  localparam logic [7:0] PT_OFS_STD_PTR = 8'h0c;
  localparam logic [7:0] PT_OFS_VND_HDR = 8'h10;
  localparam logic [7:0] PT_OFS_VND_PTR = 8'h14;
  localparam logic [31:0] PT_SIGNATURE = 32'h50444653;
  localparam logic [31:0] PT_REV_COUNT = 32'hff010100;
  localparam logic [31:0] PT_STD_HDR = 32'h09010000;
  localparam logic [31:0] PT_STD_PTR = 32'hff000030;
  localparam logic [23:0] PT_VND_REV_LEN = 24'h030100;
  localparam logic [31:0] PT_VND_PTR = 32'hff000060;
  localparam logic [31:0] PT_BLANK = 32'hffffffff;

  // ************************************************************
  // volatile state fields
  // ************************************************************
  localparam int VOL_WLATCH_BIT = 0;
  localparam int VOL_SUSPEND_BIT = 1;
  localparam int VOL_CRM_LSB = 2;
  localparam int VOL_RDP_LSB = 10;
  localparam int VOL_WRAP_LSB = 18;
  localparam int VOL_W = 21;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RST_NS = 60000;
  localparam int RST_CYCLES = T_RST_NS / CLK_PERIOD_NS;
  localparam int RST_CW = 16;
  localparam int SCLK_HALF_DEF = 20;
  localparam int DIV_W = 16;

  // ************************************************************
  // controller registers
  // ************************************************************
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_ADDR = 8'h04;
  localparam logic [7:0] HR_STATUS = 8'h08;
  localparam logic [7:0] HR_RDATA = 8'h0c;
  localparam int CMD_ADDR_BIT = 8;
  localparam int CMD_DUMMY_BIT = 9;
  localparam int CMD_NRD_LSB = 10;
  localparam int CMD_W = 13;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_CMD = 3'h1,
    DS_ADDR = 3'h2,
    DS_DUMMY = 3'h3,
    DS_DATA = 3'h4,
    DS_TAIL = 3'h5,
    DS_SKIP = 3'h6
  } fsr_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_LOAD = 3'h1,
    HS_SHIFT = 3'h2,
    HS_END = 3'h3,
    HS_GAP = 3'h4
  } fsr_host_state_t;

endpackage : fsr_pkg

/* File: core/fsr_link_if.sv */
interface fsr_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;

  modport dev (
    input cs_n,
    input sclk,
    input si,
    output so
  );

  modport host (
    output cs_n,
    output sclk,
    output si,
    input so
  );
endinterface : fsr_link_if

/* File: core/fsr_host.sv */
module fsr_host #(
  parameter int SCLK_HALF = fsr_pkg::SCLK_HALF_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  fsr_link_if.host link
);

  if (SCLK_HALF < 4 || SCLK_HALF >= 2 ** fsr_pkg::DIV_W) begin : g_bad_div
    $error("SCLK_HALF out of range");
  end

  localparam logic [fsr_pkg::DIV_W-1:0] HALF_LAST = fsr_pkg::DIV_W'(SCLK_HALF - 1);

  // ************************************************************
  // apb slave
  // ************************************************************
  fsr_pkg::fsr_host_state_t hst_q;
  logic [fsr_pkg::CMD_W-1:0] cmd_q;
  logic [23:0] addr_q;
  logic [31:0] rdata_q, prdata_q, rd_mux;
  logic pready_q, pslverr_q, done_q, mapped;
  logic setup, acc, wr_cmd, half_done;

  always_comb begin
    setup = i_psel & ~i_penable;
    acc = i_psel & i_penable & pready_q;
    wr_cmd = acc & i_pwrite & (i_paddr == fsr_pkg::HR_CMD) & (hst_q == fsr_pkg::HS_IDLE);
    mapped = 1'b1;
    case (i_paddr)
      fsr_pkg::HR_CMD: rd_mux = {19'h00000, cmd_q};
      fsr_pkg::HR_ADDR: rd_mux = {8'h00, addr_q};
      fsr_pkg::HR_STATUS: rd_mux = {30'h00000000, done_q, hst_q != fsr_pkg::HS_IDLE};
      fsr_pkg::HR_RDATA: rd_mux = rdata_q;
      default: begin
        rd_mux = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  // one wait-free access phase: the answer is prepared during setup
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~i_pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // a command written while a frame runs is dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cmd_q <= '0;
      addr_q <= 24'h000000;
    end else if (acc && i_pwrite && i_paddr == fsr_pkg::HR_ADDR) begin
      addr_q <= i_pwdata[23:0];
    end else if (wr_cmd) begin
      cmd_q <= i_pwdata[fsr_pkg::CMD_W-1:0];
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;

  // ************************************************************
  // link engine
  // ************************************************************
  logic [fsr_pkg::DIV_W-1:0] div_q;
  logic [39:0] tx_q, tx_word;
  logic [6:0] bcnt_q, nout_q, ntot_q, nout_d, rb;
  logic [2:0] nrd;
  logic sclk_q, cs_n_q, si_q, so_s1_q, so_s2_q;

  always_comb begin
    half_done = (div_q == HALF_LAST);
    tx_word = {cmd_q[7:0], cmd_q[fsr_pkg::CMD_ADDR_BIT] ? addr_q : 24'h000000, 8'h00};
    nout_d = fsr_pkg::OP_BITS
      + (cmd_q[fsr_pkg::CMD_ADDR_BIT] ? fsr_pkg::ADDR_BITS : 7'h00)
      + (cmd_q[fsr_pkg::CMD_DUMMY_BIT] ? fsr_pkg::DUMMY_BITS : 7'h00);
    nrd = cmd_q[fsr_pkg::CMD_NRD_LSB +: 3];
    if (nrd > fsr_pkg::MAX_RD_BYTES) begin
      nrd = fsr_pkg::MAX_RD_BYTES;
    end
    rb = bcnt_q - nout_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      so_s1_q <= 1'b0;
      so_s2_q <= 1'b0;
    end else begin
      so_s1_q <= link.so;
      so_s2_q <= so_s1_q;
    end
  end

  // one command per select frame, so enable and reset always go apart
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hst_q <= fsr_pkg::HS_IDLE;
      div_q <= '0;
      tx_q <= '0;
      bcnt_q <= 7'h00;
      nout_q <= 7'h00;
      ntot_q <= 7'h00;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      si_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      div_q <= half_done ? '0 : div_q + 1'b1;
      case (hst_q)
        fsr_pkg::HS_IDLE: begin
          div_q <= '0;
          if (wr_cmd) begin
            hst_q <= fsr_pkg::HS_LOAD;
          end
        end
        fsr_pkg::HS_LOAD: begin
          cs_n_q <= 1'b0;
          si_q <= tx_word[39];
          tx_q <= {tx_word[38:0], 1'b0};
          nout_q <= nout_d;
          ntot_q <= nout_d + {1'b0, nrd, 3'b000};
          bcnt_q <= 7'h00;
          rdata_q <= 32'h00000000;
          div_q <= '0;
          hst_q <= fsr_pkg::HS_SHIFT;
        end
        fsr_pkg::HS_SHIFT: begin
          if (half_done) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              bcnt_q <= bcnt_q + 7'h01;
              if (bcnt_q >= nout_q) begin
                rdata_q[{rb[4:3], ~rb[2:0]}] <= so_s2_q;
              end
            end else if (bcnt_q == ntot_q) begin
              hst_q <= fsr_pkg::HS_END;
            end else begin
              si_q <= tx_q[39];
              tx_q <= {tx_q[38:0], 1'b0};
            end
          end
        end
        fsr_pkg::HS_END: begin
          if (half_done) begin
            cs_n_q <= 1'b1;
            si_q <= 1'b0;
            hst_q <= fsr_pkg::HS_GAP;
          end
        end
        fsr_pkg::HS_GAP: begin
          if (half_done) begin
            hst_q <= fsr_pkg::HS_IDLE;
          end
        end
        default: hst_q <= fsr_pkg::HS_IDLE;
      endcase
    end
  end

  // set wins over the clear of a new command
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      done_q <= 1'b0;
    end else if (hst_q == fsr_pkg::HS_GAP && half_done) begin
      done_q <= 1'b1;
    end else if (wr_cmd) begin
      done_q <= 1'b0;
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.si = si_q;

endmodule : fsr_host

/* File: tb/fsr_assertions.sv */
module fsr_assertions (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // link timing
  // ****
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_hi;
    sclk [*4];
  endsequence
  sequence s_lo;
    !sclk [*4];
  endsequence
  a_si_at_rise: assert property ($rose(sclk) |-> $stable(si))
    else $error("si moved at a rising link clock");
  a_hi_half: assert property ($rose(sclk) |-> s_hi)
    else $error("link clock high phase too short");
  a_so_on_fall: assert property ($changed(so) |-> !sclk)
    else $error("so moved while link clock high");
  a_lo_half: assert property ($fell(sclk) |-> s_lo)
    else $error("link clock low phase too short");
  a_so_idle: assert property (cs_n [*8] |-> so == 1'b0)
    else $error("so not released outside a frame");
  a_clk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  a_frame_start: assert property ($fell(cs_n) |-> s_lo)
    else $error("link clock rose too soon after select");
  a_frame_end: assert property ($rose(cs_n) |-> !$past(sclk, 4))
    else $error("select rose too soon after a falling edge");
endmodule : fsr_assertions

/* File: tb/fsr_test.sv */
module fsr_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RST_N = 2000;
  localparam logic [7:0] VID = 8'h3c; // arbitrary value
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, perr;
  logic [7:0] paddr = 8'h00, otp_d = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, busy, otp_we = 0, lock = 0, vol_we = 0;
  logic [9:0] otp_a = 10'h000;
  logic [20:0] vol_d = 21'h0, vol_q;
  int failures = 0, n_checks = 0;
  logic [31:0] hdr [7] = '{32'h50444653, 32'hff010100, 32'h09010000, 32'hff000030,
    {24'h030100, VID}, 32'hff000060, 32'hffffffff};
  fsr_link_if link ();
  fsr_dev #(.RST_CYCLES(RST_N), .VENDOR_ID(VID)) fsr_dev_i (.i_ref_clk(clk), .i_reset(rst),
    .link(link.dev), .i_otp_we(otp_we), .i_otp_addr(otp_a), .i_otp_data(otp_d),
    .i_lock_flag(lock), .i_vol_we(vol_we), .i_vol_data(vol_d), .o_vol_state(vol_q),
    .o_reset_busy(busy));
  fsr_host #(.SCLK_HALF(20)) fsr_host_i (.i_ref_clk(clk), .i_reset(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link.host));
  fsr_assertions fsr_assertions_i (.i_ref_clk(clk), .i_reset(rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .si(link.si), .so(link.so));
  initial begin
    forever #2 clk = ~clk;
  end
  // ****
  // access tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic frame(input logic [12:0] c, input logic [23:0] a);
    int n;
    apb(1'b1, 8'h04, {8'h00, a});
    apb(1'b1, 8'h00, {19'h0, c});
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (r[1] !== 1'b1 && n < 5000);
    chk({31'h0, r[1]}, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
  endtask : frame
  task automatic rst_try(input logic [12:0] c, input logic e);
    chk({30'h0, busy, vol_q[fsr_pkg::VOL_SUSPEND_BIT]}, 32'h0);
    frame(c, 24'h0);
    frame(13'h0099, 24'h0);
    chk({31'h0, busy}, {31'h0, e});
  endtask : rst_try
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #360000;
    failures++;
    complete_run();
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({29'h0, link.cs_n, link.sclk, link.so}, 32'h4);
    chk({10'h0, busy, vol_q}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({perr, r[30:0]}, 32'h80000000);
    for (int i = 0; i < 7; i++) begin
      frame(13'h135a, 24'(i * 4));
      chk(r, hdr[i]);
    end
    for (int k = 0; k < 4; k++) begin
      otp_we <= 1'b1;
      otp_a <= 10'h3fe + 10'(k);
      otp_d <= 8'ha0 + 8'(k);
      @(posedge clk);
    end
    lock <= 1'b1;
    otp_a <= 10'h3fe;
    otp_d <= 8'h55;
    @(posedge clk);
    otp_we <= 1'b0;
    frame(13'h1348, 24'h0003fe);
    chk(r, 32'ha3a2a1a0);
    vol_we <= 1'b1;
    vol_d <= 21'h15a5a5;
    @(posedge clk);
    vol_we <= 1'b0;
    rst_try(13'h0466, 1'b0);
    rst_try(13'h135a, 1'b0);
    chk({11'h0, vol_q}, 32'h15a5a5);
    rst_try(13'h0066, 1'b1);
    chk({11'h0, vol_q}, 32'h0);
    frame(13'h135a, 24'h0);
    chk(r, 32'h0);
    for (int n = 0; n < RST_N && busy; n++) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    frame(13'h135a, 24'h0);
    chk(r, hdr[0]);
    complete_run();
  end
endmodule : fsr_test
